// >>> dv/tlnic_chk.sv
// concurrent checks on the call handshake and the register bus of tlnic_top
// assumes one clock domain, reset active low and asynchronous
`timescale 1ns/100ps
`include "tlnic_regs.svh"
module tlnic_chk (
    input wire logic REF_CLK_IN,
    input wire logic NRST_IN,
    input wire logic INSTR_END_IN,
    input wire logic CALL_ACK_IN,
    input wire logic CALL_REQ_OUT,
    input wire logic [15:0] CALL_VECTOR_OUT,
    input wire logic [1:0] SP_STEP_OUT,
    input wire logic ARVALID_IN,
    input wire logic ARREADY_OUT,
    input wire logic RVALID_OUT,
    input wire logic RREADY_IN,
    input wire logic BVALID_OUT,
    input wire logic BREADY_IN
);
    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!NRST_IN);
    a_vec_legal: assert property (CALL_REQ_OUT |-> CALL_VECTOR_OUT inside
        {`TLNIC_VEC_EXT0, `TLNIC_VEC_TMR0, `TLNIC_VEC_EXT1, `TLNIC_VEC_TMR1, `TLNIC_VEC_SER})
        else $error("call vector outside the five entries");
    a_sp_two: assert property (CALL_REQ_OUT |-> SP_STEP_OUT == `TLNIC_SP_STEP)
        else $error("stack step not two during a call");
    a_call_at_end: assert property ($rose(CALL_REQ_OUT) |-> $past(INSTR_END_IN))
        else $error("call raised away from instruction end");
    a_hold_to_ack: assert property (CALL_REQ_OUT && !CALL_ACK_IN |=>
        CALL_REQ_OUT && $stable(CALL_VECTOR_OUT))
        else $error("call request or vector changed before ack");
    a_ack_drop: assert property (CALL_REQ_OUT && CALL_ACK_IN |=> !CALL_REQ_OUT)
        else $error("call request held after ack");
    a_rst_quiet: assert property ($rose(NRST_IN) |-> !CALL_REQ_OUT && SP_STEP_OUT == 2'h0)
        else $error("call outputs not cleared by reset");
    a_read_answer: assert property (ARVALID_IN && ARREADY_OUT |=> RVALID_OUT)
        else $error("read answer late");
    a_rvalid_hold: assert property (RVALID_OUT && !RREADY_IN |=> RVALID_OUT)
        else $error("read valid dropped before ready");
    a_bvalid_hold: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT)
        else $error("write response dropped before ready");
endmodule
bind tlnic_top tlnic_chk i_chk (.REF_CLK_IN(REF_CLK_IN), .NRST_IN(NRST_IN),
    .INSTR_END_IN(INSTR_END_IN), .CALL_ACK_IN(CALL_ACK_IN), .CALL_REQ_OUT(CALL_REQ_OUT),
    .CALL_VECTOR_OUT(CALL_VECTOR_OUT), .SP_STEP_OUT(SP_STEP_OUT), .ARVALID_IN(ARVALID_IN),
    .ARREADY_OUT(ARREADY_OUT), .RVALID_OUT(RVALID_OUT), .RREADY_IN(RREADY_IN),
    .BVALID_OUT(BVALID_OUT), .BREADY_IN(BREADY_IN));

// >>> dv/tlnic_cpu_model.sv
// cpu sequencer model: 12-cycle instructions, latch strobes, call ack, return pulse
// assumes the bench sets the ack delay and asks for returns
`timescale 1ns/100ps
module tlnic_cpu_model (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic call_req_in,
    input wire logic interrupt_return_instr_cmd_in,
    input wire logic [3:0] ack_dly_in,
    output logic strobe_out,
    output logic end_out,
    output logic ack_out,
    output logic interrupt_return_instr_out
);
    logic [3:0] phase;
    logic [3:0] wait_cnt;
    logic acked;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            {phase, wait_cnt} <= 8'h00;
            {acked, strobe_out, end_out, ack_out, interrupt_return_instr_out} <= 5'h00;
        end else begin
            phase <= (phase == 4'hB) ? 4'h0 : phase + 4'h1;
            strobe_out <= (phase == 4'h3) || (phase == 4'h9);
            end_out <= (phase == 4'hB);
            ack_out <= 1'h0;
            // never return while a call is open, the two pulses must not meet
            interrupt_return_instr_out <= interrupt_return_instr_cmd_in && !call_req_in;
            if (!call_req_in) begin
                acked <= 1'h0;
                wait_cnt <= 4'h0;
            end else if (!acked && wait_cnt == ack_dly_in) begin
                ack_out <= 1'h1;
                acked <= 1'h1;
            end else if (!acked) begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule

// >>> dv/two_level_nested_irq_ctrl_bench.sv
// bench for the nested irq controller: axi tasks, cpu model, call monitor
// assumes tlnic_top, tlnic_cpu_model and the checker bind are compiled first
`timescale 1ns/100ps
`include "tlnic_regs.svh"
`define CHK(nm, ex, got) begin samples_checked++; \
    if ((got) !== (ex)) begin err_total++; \
    $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module two_level_nested_irq_ctrl_bench;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic pin0 = 1'h1, pin1 = 1'h1, t0 = 1'h0, t1 = 1'h0, utx = 1'h0, urx = 1'h0;
    logic interrupt_return_instr_cmd = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] ack_dly = 4'h1;
    logic strobe, iend, ack, interrupt_return_instr, call_req, awready, wready, bvalid, arready, rvalid;
    logic [15:0] vec, v;
    logic [1:0] sp_step, bresp, rresp, resp;
    logic [15:0] seen[$];
    logic [15:0] vecs[5] = '{`TLNIC_VEC_EXT0, `TLNIC_VEC_TMR0, `TLNIC_VEC_EXT1,
        `TLNIC_VEC_TMR1, `TLNIC_VEC_SER};
    int err_total = 0;
    int samples_checked = 0;
    initial forever #12.5 clk = ~clk;
    tlnic_top i_dut (.REF_CLK_IN(clk), .NRST_IN(nrst), .EXT_IRQ0_PIN_N_IN(pin0),
        .EXT_IRQ1_PIN_N_IN(pin1), .TIMER0_OVF_IN(t0), .TIMER1_OVF_IN(t1), .UART_TX_DONE_IN(utx),
        .UART_RX_DONE_IN(urx), .LATCH_STROBE_IN(strobe), .INSTR_END_IN(iend), .CALL_ACK_IN(ack),
        .INTERRUPT_RETURN_INSTR_IN(interrupt_return_instr), .CALL_REQ_OUT(call_req), .CALL_VECTOR_OUT(vec), .SP_STEP_OUT(sp_step),
        .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready), .WDATA_IN(wdata),
        .WSTRB_IN(4'hF), .WVALID_IN(wvalid), .WREADY_OUT(wready), .BRESP_OUT(bresp),
        .BVALID_OUT(bvalid), .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid),
        .ARREADY_OUT(arready), .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid),
        .RREADY_IN(rready));
    tlnic_cpu_model i_cpu (.clk_in(clk), .nrst_in(nrst), .call_req_in(call_req),
        .interrupt_return_instr_cmd_in(interrupt_return_instr_cmd), .ack_dly_in(ack_dly), .strobe_out(strobe), .end_out(iend),
        .ack_out(ack), .interrupt_return_instr_out(interrupt_return_instr));
    // a call counts once, at its ack edge
    always @(posedge clk) begin
        if (call_req && ack) begin
            seen.push_back(vec);
            `CHK("sp_step", `TLNIC_SP_STEP, sp_step)
        end
    end
    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (n < 50) begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bready && bvalid) break;
            if (bvalid) bready <= 1'h1;
        end
        resp = bresp;
        bready <= 1'h0;
        if (n >= 50) err_total++;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ex,
        input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'h1;
        while (n < 50) begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'h0;
            if (rready && rvalid) break;
            if (rvalid) rready <= 1'h1;
        end
        rready <= 1'h0;
        if (n >= 50) err_total++;
        `CHK("rdata", ex, rdata & m)
        `CHK("rresp", er, rresp)
    endtask
    // pins held low then high long enough for two strobes each
    task automatic fire(input logic [4:0] m);
        {pin0, t0, pin1, t1, utx, urx} <= {!m[0], m[1], !m[2], m[3], m[4], m[4]};
        @(posedge clk);
        {t0, t1, utx, urx} <= 4'h0;
        repeat (14) @(posedge clk);
        {pin0, pin1} <= 2'h3;
        repeat (14) @(posedge clk);
    endtask
    task automatic serve(input logic [15:0] ex);
        int n;
        n = 0;
        while (seen.size() == 0 && n < 86) begin
            @(posedge clk);
            n++;
        end
        v = (seen.size() > 0) ? seen.pop_front() : 16'hFFFF;
        `CHK("vector", ex, v)
    endtask
    task automatic no_call(input int n);
        repeat (n) @(posedge clk);
        `CHK("calls", 0, seen.size())
    endtask
    task automatic ret();
        interrupt_return_instr_cmd <= 1'h1;
        @(posedge clk);
        interrupt_return_instr_cmd <= 1'h0;
        @(posedge clk);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'h1;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 5; i++) rdc(8'(4 * i), 32'hFF, 32'h0, `TLNIC_RESP_OKAY);
        rdc(8'h14, 32'hFFFFFFFF, 32'h0, `TLNIC_RESP_SLVERR);
        wr(8'h14, 32'hFF);
        `CHK("bresp", `TLNIC_RESP_SLVERR, resp)
        wr(`TLNIC_OFS_TCTL, 32'h05);
        wr(`TLNIC_OFS_IEN, 32'h1F);
        fire(5'h1F);
        no_call(20);
        rdc(`TLNIC_OFS_TCTL, 32'hFF, 32'hAF, `TLNIC_RESP_OKAY);
        rdc(`TLNIC_OFS_UCTL, 32'hFF, 32'h03, `TLNIC_RESP_OKAY);
        ack_dly <= 4'h6;
        wr(`TLNIC_OFS_IEN, 32'h9F);
        for (int i = 0; i < 5; i++) begin
            serve(vecs[i]);
            if (i == 4) begin
                rdc(`TLNIC_OFS_UCTL, 32'hFF, 32'h03, `TLNIC_RESP_OKAY);
                rdc(`TLNIC_OFS_TCTL, 32'hFF, 32'h05, `TLNIC_RESP_OKAY);
                wr(`TLNIC_OFS_UCTL, 32'h00);
                repeat (14) @(posedge clk);
            end
            ret();
        end
        ack_dly <= 4'h0;
        wr(`TLNIC_OFS_IPR, 32'h08);
        wr(`TLNIC_OFS_IEN, 32'h8A);
        fire(5'h02);
        serve(`TLNIC_VEC_TMR0);
        rdc(`TLNIC_OFS_STAT, 32'hFF, 32'h09, `TLNIC_RESP_OKAY);
        fire(5'h08);
        serve(`TLNIC_VEC_TMR1);
        rdc(`TLNIC_OFS_STAT, 32'hFF, 32'h1F, `TLNIC_RESP_OKAY);
        fire(5'h02);
        no_call(40);
        ret();
        rdc(`TLNIC_OFS_STAT, 32'hFF, 32'h1D, `TLNIC_RESP_OKAY);
        no_call(40);
        fire(5'h08);
        serve(`TLNIC_VEC_TMR1);
        ret();
        ret();
        serve(`TLNIC_VEC_TMR0);
        ret();
        wr(`TLNIC_OFS_TCTL, 32'h00);
        wr(`TLNIC_OFS_IEN, 32'h84);
        pin1 <= 1'h0;
        serve(`TLNIC_VEC_EXT1);
        ret();
        serve(`TLNIC_VEC_EXT1);
        pin1 <= 1'h1;
        repeat (14) @(posedge clk);
        ret();
        no_call(40);
        summarize();
    end
endmodule

// >>> src/tlnic_pkg.sv
// types shared by the nested irq controller
// assumes nothing beyond the constants header
package tlnic_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CALL = 2'b10
    } tlnic_state_e;
    typedef logic [4:0] tlnic_src_t;
    typedef logic [2:0] tlnic_idx_t;
endpackage

// >>> src/tlnic_regs.svh
// register offsets, field positions, vectors and timing for the nested irq controller
// assumes a 40 MHz clock and a cpu sequencer that drives the strobe, end and ack inputs
//
// Overview of operation
// - five request sources: two external pins, two timer overflows, serial port.
// - each source has an enable; global enable gates all enabled requests.
// - per-source priority bit; one means high level, zero low level.
// - a request is taken only when enabled and highest priority requesting.
// - same-level tie order: ext0, timer0, ext1, timer1, serial.
// - vectors 0003h, 000Bh, 0013h, 001Bh, 0023h for the five sources.
// - request flags sit at timer control bits 1,5,3,7 and uart bits 1,0.
// - service starts only at the end of the current instruction.
// - high level preempts low routine; same or lower level never preempts.
// - two hidden level-active flops, set when control moves to a routine; the code shows them in status bits 1 and 0.
// - return instruction clears only the active flop of the level in service.
// - inputs latched at the 10th, 22nd, 34th, 46th periods by a strobe.
// - acknowledge sets level flop and requests a call pushing only the pc.
// - ext and timer flags auto-clear on entry; serial flags cleared by software.
// - nested entry pushes return address, stack pointer advances by two.
// - after nested high return, low flop stays set; low requests stay blocked.
// - external inputs active low, each level or transition triggered.
// - response latency between 3us and 7us at a 12 MHz crystal.
// - edge select one: falling edge sets flag; zero: low level requests.
// - request to first service instruction takes at most 86 oscillator periods.
`ifndef TLNIC_REGS_SVH
`define TLNIC_REGS_SVH

`define TLNIC_OFS_TCTL 8'h00
`define TLNIC_OFS_UCTL 8'h04
`define TLNIC_OFS_IEN 8'h08
`define TLNIC_OFS_IPR 8'h0C
`define TLNIC_OFS_STAT 8'h10

`define TLNIC_B_EDGE0 0
`define TLNIC_B_EXT0 1
`define TLNIC_B_EDGE1 2
`define TLNIC_B_EXT1 3
`define TLNIC_B_TMR0 5
`define TLNIC_B_TMR1 7
`define TLNIC_B_RX 0
`define TLNIC_B_TX 1
`define TLNIC_B_GIE 7
`define TLNIC_B_LATOVR 7

`define TLNIC_SRC_EXT0 3'h0
`define TLNIC_SRC_TMR0 3'h1
`define TLNIC_SRC_EXT1 3'h2
`define TLNIC_SRC_TMR1 3'h3
`define TLNIC_SRC_SER 3'h4

`define TLNIC_VEC_EXT0 16'h0003
`define TLNIC_VEC_TMR0 16'h000B
`define TLNIC_VEC_EXT1 16'h0013
`define TLNIC_VEC_TMR1 16'h001B
`define TLNIC_VEC_SER 16'h0023

`define TLNIC_SP_STEP 2'h2
`define TLNIC_RESP_OKAY 2'h0
`define TLNIC_RESP_SLVERR 2'h2
`define TLNIC_CLK_MHZ 40
`define TLNIC_LAT_MAX_NS 7000
`define TLNIC_LAT_MAX_CYC ((`TLNIC_LAT_MAX_NS * `TLNIC_CLK_MHZ) / 1000)

`endif

// >>> src/tlnic_top.sv
// two-level nested interrupt controller with an axi4-lite register slave
// assumes the cpu sequencer pulses LATCH_STROBE_IN, INSTR_END_IN, CALL_ACK_IN and INTERRUPT_RETURN_INSTR_IN
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
`include "tlnic_regs.svh"

module tlnic_top (
    input wire logic REF_CLK_IN,
    input wire logic NRST_IN,
    input wire logic EXT_IRQ0_PIN_N_IN,
    input wire logic EXT_IRQ1_PIN_N_IN,
    input wire logic TIMER0_OVF_IN,
    input wire logic TIMER1_OVF_IN,
    input wire logic UART_TX_DONE_IN,
    input wire logic UART_RX_DONE_IN,
    input wire logic LATCH_STROBE_IN,
    input wire logic INSTR_END_IN,
    input wire logic CALL_ACK_IN,
    input wire logic INTERRUPT_RETURN_INSTR_IN,
    output logic CALL_REQ_OUT,
    output logic [15:0] CALL_VECTOR_OUT,
    output logic [1:0] SP_STEP_OUT,
    input wire logic [7:0] AWADDR_IN,
    input wire logic AWVALID_IN,
    output logic AWREADY_OUT,
    input wire logic [31:0] WDATA_IN,
    input wire logic [3:0] WSTRB_IN,
    input wire logic WVALID_IN,
    output logic WREADY_OUT,
    output logic [1:0] BRESP_OUT,
    output logic BVALID_OUT,
    input wire logic BREADY_IN,
    input wire logic [7:0] ARADDR_IN,
    input wire logic ARVALID_IN,
    output logic ARREADY_OUT,
    output logic [31:0] RDATA_OUT,
    output logic [1:0] RRESP_OUT,
    output logic RVALID_OUT,
    input wire logic RREADY_IN
);

    // first set bit in fixed tie order, lowest index wins
    function automatic tlnic_pkg::tlnic_idx_t pick(input tlnic_pkg::tlnic_src_t m);
        tlnic_pkg::tlnic_idx_t r;
        r = `TLNIC_SRC_SER;
        if (m[`TLNIC_SRC_TMR1]) r = `TLNIC_SRC_TMR1;
        if (m[`TLNIC_SRC_EXT1]) r = `TLNIC_SRC_EXT1;
        if (m[`TLNIC_SRC_TMR0]) r = `TLNIC_SRC_TMR0;
        if (m[`TLNIC_SRC_EXT0]) r = `TLNIC_SRC_EXT0;
        return r;
    endfunction

    // flag update: hardware set beats both software write and hardware clear
    function automatic logic nflag(input logic cur, input logic set, input logic wr,
                                   input logic wb, input logic clr);
        return set | (wr ? wb : (cur & ~clr));
    endfunction

    // only the five mapped words answer okay, the rest get a slave error
    function automatic logic addr_ok(input logic [7:0] a);
        return a == `TLNIC_OFS_TCTL || a == `TLNIC_OFS_UCTL || a == `TLNIC_OFS_IEN ||
               a == `TLNIC_OFS_IPR || a == `TLNIC_OFS_STAT;
    endfunction

    tlnic_pkg::tlnic_state_e state;
    tlnic_pkg::tlnic_state_e next_state;
    logic [1:0] edge_sel;
    logic [1:0] ext_flag;
    logic [1:0] tmr_flag;
    logic tx_flag;
    logic rx_flag;
    tlnic_pkg::tlnic_src_t ien;
    logic gie;
    tlnic_pkg::tlnic_src_t ipr;
    logic act_hi;
    logic act_lo;
    logic [1:0] pin_lvl;
    tlnic_pkg::tlnic_src_t latched;
    tlnic_pkg::tlnic_idx_t cur_src;
    logic cur_hi;
    logic [8:0] lat_cnt;
    logic lat_over;

    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic w_lane0;

    // request sources in tie order ext0, tmr0, ext1, tmr1, serial
    wire [1:0] ext_req = (edge_sel & ext_flag) | (~edge_sel & ~pin_lvl);
    wire ser_req = tx_flag | rx_flag;
    wire tlnic_pkg::tlnic_src_t src_now = {ser_req, tmr_flag[1], ext_req[1], tmr_flag[0],
                                           ext_req[0]};
    // a fall is high at the previous strobe and low at this one
    wire [1:0] ext_fall = edge_sel & pin_lvl & {~EXT_IRQ1_PIN_N_IN, ~EXT_IRQ0_PIN_N_IN};
    wire [1:0] ext_set = ext_fall & {2{LATCH_STROBE_IN}};

    // eligibility and two-level arbitration against the level-active flops
    // global enable gates last, so clearing it blocks every source at once
    wire tlnic_pkg::tlnic_src_t elig = latched & ien & {5{gie}};
    wire tlnic_pkg::tlnic_src_t hi_m = elig & ipr;
    wire tlnic_pkg::tlnic_src_t lo_m = elig & ~ipr;
    wire hi_ok = (|hi_m) & ~act_hi;
    // a low routine in service keeps further low requests out until its return
    wire lo_ok = (|lo_m) & ~act_hi & ~act_lo;
    wire tlnic_pkg::tlnic_idx_t win = hi_ok ? pick(hi_m) : pick(lo_m);
    // pending also feeds the latency watch below
    wire pending = hi_ok | lo_ok;
    // calls start only at an instruction boundary
    wire take = (state == tlnic_pkg::ST_IDLE) & INSTR_END_IN & pending;
    wire ack = (state == tlnic_pkg::ST_CALL) & CALL_ACK_IN;

    wire [15:0] win_vec = (win == `TLNIC_SRC_EXT0) ? `TLNIC_VEC_EXT0 :
                          (win == `TLNIC_SRC_TMR0) ? `TLNIC_VEC_TMR0 :
                          (win == `TLNIC_SRC_EXT1) ? `TLNIC_VEC_EXT1 :
                          (win == `TLNIC_SRC_TMR1) ? `TLNIC_VEC_TMR1 :
                          `TLNIC_VEC_SER;

    // flags cleared by hardware on entry; serial flags are left for software
    wire clr_ext0 = ack & (cur_src == `TLNIC_SRC_EXT0);
    wire clr_ext1 = ack & (cur_src == `TLNIC_SRC_EXT1);
    wire clr_tmr0 = ack & (cur_src == `TLNIC_SRC_TMR0);
    wire clr_tmr1 = ack & (cur_src == `TLNIC_SRC_TMR1);

    // register bus decode
    wire aw_go = AWVALID_IN & AWREADY_OUT;
    wire w_go = WVALID_IN & WREADY_OUT;
    // write lands one cycle after both halves are held, on the same edge as the response
    wire wr_do = aw_hold & w_hold & ~BVALID_OUT;
    wire wr_ok = wr_do & addr_ok(aw_addr) & w_lane0;
    wire wr_tctl = wr_ok & (aw_addr == `TLNIC_OFS_TCTL);
    wire wr_uctl = wr_ok & (aw_addr == `TLNIC_OFS_UCTL);
    wire wr_ien = wr_ok & (aw_addr == `TLNIC_OFS_IEN);
    wire wr_ipr = wr_ok & (aw_addr == `TLNIC_OFS_IPR);
    wire wr_stat = wr_ok & (aw_addr == `TLNIC_OFS_STAT);
    wire [7:0] wb = w_data[7:0];
    wire next_aw_hold = (aw_hold | aw_go) & ~wr_do;
    wire next_w_hold = (w_hold | w_go) & ~wr_do;
    wire next_bvalid = wr_do | (BVALID_OUT & ~BREADY_IN);
    wire ar_go = ARVALID_IN & ARREADY_OUT;
    wire next_rvalid = ar_go | (RVALID_OUT & ~RREADY_IN);

    wire [7:0] rd_tctl = {tmr_flag[1], 1'b0, tmr_flag[0], 1'b0, ext_flag[1], edge_sel[1],
                          ext_flag[0], edge_sel[0]};
    wire [7:0] rd_uctl = {6'h00, tx_flag, rx_flag};
    wire [7:0] rd_ien = {gie, 2'h0, ien};
    wire [7:0] rd_ipr = {3'h0, ipr};
    // status: latency overrun, call pending, source in call, level flops
    wire [7:0] rd_stat = {lat_over, state == tlnic_pkg::ST_CALL, cur_src, cur_hi, act_hi,
                          act_lo};
    wire [7:0] rd_byte = (ARADDR_IN == `TLNIC_OFS_TCTL) ? rd_tctl :
                         (ARADDR_IN == `TLNIC_OFS_UCTL) ? rd_uctl :
                         (ARADDR_IN == `TLNIC_OFS_IEN) ? rd_ien :
                         (ARADDR_IN == `TLNIC_OFS_IPR) ? rd_ipr :
                         (ARADDR_IN == `TLNIC_OFS_STAT) ? rd_stat : 8'h00;

    // latency watch: an eligible request left waiting longer than the bound
    wire lat_run = pending | (state == tlnic_pkg::ST_CALL);
    wire lat_hit = lat_run & (lat_cnt == 9'(`TLNIC_LAT_MAX_CYC));
    // saturates at the bound so the overrun cannot wrap away unseen
    wire [8:0] next_lat_cnt = (ack | ~lat_run) ? 9'h000 :
                              (lat_hit ? lat_cnt : lat_cnt + 9'h001);

    always_comb begin
        next_state = state;
        unique case (state)
            tlnic_pkg::ST_IDLE: begin
                if (take) begin
                    next_state = tlnic_pkg::ST_CALL;
                end
            end
            tlnic_pkg::ST_CALL: begin
                if (CALL_ACK_IN) begin
                    next_state = tlnic_pkg::ST_IDLE;
                end
            end
            default: next_state = tlnic_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            state <= tlnic_pkg::ST_IDLE;
            cur_src <= `TLNIC_SRC_EXT0;
            cur_hi <= 1'b0;
            CALL_REQ_OUT <= 1'b0;
            CALL_VECTOR_OUT <= 16'h0000;
            SP_STEP_OUT <= 2'h0;
        end else begin
            state <= next_state;
            // vector frozen at arbitration; a later software clear cannot move it
            if (take) begin
                cur_src <= win;
                cur_hi <= hi_ok;
                CALL_VECTOR_OUT <= win_vec;
                SP_STEP_OUT <= `TLNIC_SP_STEP;
            end
            // rises the cycle after the instruction end and stands until the ack
            CALL_REQ_OUT <= (next_state == tlnic_pkg::ST_CALL);
        end
    end

    // level-active flops; a return drops the higher one only
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            act_hi <= 1'b0;
            act_lo <= 1'b0;
        end else begin
            if (ack & cur_hi) begin
                act_hi <= 1'b1;
            end else if (INTERRUPT_RETURN_INSTR_IN & act_hi) begin
                act_hi <= 1'b0;
            end
            if (ack & ~cur_hi) begin
                act_lo <= 1'b1;
            end else if (INTERRUPT_RETURN_INSTR_IN & ~act_hi) begin
                act_lo <= 1'b0;
            end
        end
    end

    // pin sampling and request latch on the sequencer strobe
    // pins between strobes are never looked at, so short glitches pass unseen
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            pin_lvl <= 2'h3;
            latched <= 5'h00;
        end else if (LATCH_STROBE_IN) begin
            pin_lvl <= {EXT_IRQ1_PIN_N_IN, EXT_IRQ0_PIN_N_IN};
            latched <= src_now;
        end
    end

    // next values of the request flags; serial ones have no hardware clear
    wire next_ext0_flag = nflag(ext_flag[0], ext_set[0], wr_tctl, wb[`TLNIC_B_EXT0],
                                clr_ext0);
    wire next_ext1_flag = nflag(ext_flag[1], ext_set[1], wr_tctl, wb[`TLNIC_B_EXT1],
                                clr_ext1);
    wire next_tmr0_flag = nflag(tmr_flag[0], TIMER0_OVF_IN, wr_tctl, wb[`TLNIC_B_TMR0],
                                clr_tmr0);
    wire next_tmr1_flag = nflag(tmr_flag[1], TIMER1_OVF_IN, wr_tctl, wb[`TLNIC_B_TMR1],
                                clr_tmr1);
    wire next_tx_flag = nflag(tx_flag, UART_TX_DONE_IN, wr_uctl, wb[`TLNIC_B_TX], 1'b0);
    wire next_rx_flag = nflag(rx_flag, UART_RX_DONE_IN, wr_uctl, wb[`TLNIC_B_RX], 1'b0);

    // request flags
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            ext_flag <= 2'h0;
            tmr_flag <= 2'h0;
            tx_flag <= 1'b0;
            rx_flag <= 1'b0;
        end else begin
            ext_flag <= {next_ext1_flag, next_ext0_flag};
            tmr_flag <= {next_tmr1_flag, next_tmr0_flag};
            tx_flag <= next_tx_flag;
            rx_flag <= next_rx_flag;
        end
    end

    // control bits, changed by software writes only
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            edge_sel <= 2'h0;
            ien <= 5'h00;
            gie <= 1'b0;
            ipr <= 5'h00;
        end else begin
            if (wr_tctl) begin
                edge_sel <= {wb[`TLNIC_B_EDGE1], wb[`TLNIC_B_EDGE0]};
            end
            if (wr_ien) begin
                ien <= wb[4:0];
                gie <= wb[`TLNIC_B_GIE];
            end
            if (wr_ipr) begin
                ipr <= wb[4:0];
            end
        end
    end

    // latency watch registers
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            lat_cnt <= 9'h000;
            lat_over <= 1'b0;
        end else begin
            lat_cnt <= next_lat_cnt;
            // write one clears, a fresh overrun in the same cycle wins
            lat_over <= lat_hit | (lat_over & ~(wr_stat & wb[`TLNIC_B_LATOVR]));
        end
    end

    // axi4-lite write channels, address and data taken in either order
    // readies stay low while a response stands, so one write is in flight at most
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_lane0 <= 1'b0;
            AWREADY_OUT <= 1'b0;
            WREADY_OUT <= 1'b0;
            BVALID_OUT <= 1'b0;
            BRESP_OUT <= `TLNIC_RESP_OKAY;
        end else begin
            if (aw_go) begin
                aw_addr <= AWADDR_IN;
            end
            if (w_go) begin
                w_data <= WDATA_IN;
                w_lane0 <= WSTRB_IN[0];
            end
            aw_hold <= next_aw_hold;
            w_hold <= next_w_hold;
            AWREADY_OUT <= ~next_aw_hold & ~next_bvalid;
            WREADY_OUT <= ~next_w_hold & ~next_bvalid;
            BVALID_OUT <= next_bvalid;
            if (wr_do) begin
                BRESP_OUT <= addr_ok(aw_addr) ? `TLNIC_RESP_OKAY : `TLNIC_RESP_SLVERR;
            end
        end
    end

    // axi4-lite read channel, one read in flight
    // data captured with the address, so they hold still while valid stands
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            ARREADY_OUT <= 1'b0;
            RVALID_OUT <= 1'b0;
            RDATA_OUT <= 32'h0000_0000;
            RRESP_OUT <= `TLNIC_RESP_OKAY;
        end else begin
            ARREADY_OUT <= ~next_rvalid;
            RVALID_OUT <= next_rvalid;
            if (ar_go) begin
                RDATA_OUT <= {24'h000000, rd_byte};
                RRESP_OUT <= addr_ok(ARADDR_IN) ? `TLNIC_RESP_OKAY : `TLNIC_RESP_SLVERR;
            end
        end
    end

endmodule
